// file: ssc_pkg.sv
// package: register map, field layout and mux codes of the step-five configuration register
package ssc_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0]  STEP_FIVE_CFG_ADDR   = 8'h95;
    localparam logic [15:0] STEP_FIVE_CFG_RESET  = 16'h0005;
    localparam logic [15:0] STEP_FIVE_CFG_WMASK  = 16'hE01F;
    localparam logic [15:0] UNMAPPED_READ_VALUE  = 16'h0000;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int EN_BIT     = 15;
    localparam int GAIN_HI    = 14;
    localparam int GAIN_LO    = 13;
    localparam int NEG_BIT    = 4;
    localparam int POS_HI     = 3;
    localparam int POS_LO     = 0;
    // ****************************************************************
    // gain and input codes
    // ****************************************************************
    typedef enum logic [2:0] {
        SSC_GAIN_1 = 3'b001,
        SSC_GAIN_2 = 3'b010,
        SSC_GAIN_4 = 3'b100
    } ssc_gain_t;
    localparam logic [3:0] POS_TEMP_SENSOR = 4'h8;
    localparam logic [3:0] POS_SHORT_GND   = 4'h9;
    localparam logic [3:0] POS_TEST_SOURCE = 4'hA;
    localparam logic [3:0] POS_ANALOG_PWR  = 4'hE;
    localparam logic [3:0] POS_DIGITAL_PWR = 4'hF;
    localparam int         SUPPLY_DIVIDE   = 103;
endpackage

// file: ssc_gain_decode.sv
// gain field decoder
`timescale 1ns/100ps
`default_nettype none
module ssc_gain_decode (
    input  wire logic [1:0]       code,
    output ssc_pkg::ssc_gain_t    gain
);
    // 00 -> 1, 01 -> 2, 10 and 11 -> 4
    assign gain = (code == 2'h0) ? ssc_pkg::SSC_GAIN_1 :
                  (code == 2'h1) ? ssc_pkg::SSC_GAIN_2 : ssc_pkg::SSC_GAIN_4;
endmodule // ssc_gain_decode
`default_nettype wire

// file: ssc_input_decode.sv
// input multiplexer decoder
`timescale 1ns/100ps
`default_nettype none
module ssc_input_decode (
    input  wire logic [3:0] pos_code,
    input  wire logic       neg_sel,
    output logic      [7:0] pos_ext_onehot,
    output logic            pos_temp_sensor,
    output logic            pos_short_gnd,
    output logic            pos_test_source,
    output logic            pos_analog_pwr,
    output logic            pos_digital_pwr,
    output logic            neg_auto,
    output logic            neg_ground,
    output logic            neg_input_7
);
    wire logic external_pos;
    // ****************************************************************
    // positive side
    // ****************************************************************
    assign external_pos = ~pos_code[3];
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_ext
            assign pos_ext_onehot[i] = external_pos && (pos_code[2:0] == 3'(i));
        end
    endgenerate
    assign pos_temp_sensor = (pos_code == ssc_pkg::POS_TEMP_SENSOR);
    assign pos_short_gnd   = (pos_code == ssc_pkg::POS_SHORT_GND);
    assign pos_test_source = (pos_code == ssc_pkg::POS_TEST_SOURCE);
    assign pos_analog_pwr  = (pos_code == ssc_pkg::POS_ANALOG_PWR);
    assign pos_digital_pwr = (pos_code == ssc_pkg::POS_DIGITAL_PWR);
    // ****************************************************************
    // negative side
    // ****************************************************************
    assign neg_auto    = pos_code[3];
    assign neg_ground  = external_pos && !neg_sel;
    assign neg_input_7 = external_pos && neg_sel;
endmodule // ssc_input_decode
`default_nettype wire

// file: ssc_step_config.sv
// step-five configuration register of the auxiliary converter sequencer
//
// Operation
// - bit 15 includes step five in the sequence when set.
// - gain bits 14:13 give 1, 2, 4, 4 for codes 00..11.
// - bit 4 picks negative input: 0 analog ground, 1 analog input 7.
// - positive codes 0000..0111 route analog inputs 0 to 7.
// - codes 1000, 1001, 1010 pick temperature sensor, ground short, test source.
// - codes 1110, 1111 pick analog and digital supply divided by 103.
// - internal positive sources choose negative input automatically, ignoring bit 4.
`timescale 1ns/100ps
`default_nettype none
module ssc_step_config (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    output logic             STEP_INCLUDE_ENABLE,
    output logic      [2:0]  STEP_GAIN_ONEHOT,
    output logic      [7:0]  POS_EXTERNAL_ONEHOT,
    output logic             POS_TEMP_SENSOR,
    output logic             POS_SHORT_GND,
    output logic             POS_TEST_SOURCE,
    output logic             POS_ANALOG_PWR,
    output logic             POS_DIGITAL_PWR,
    output logic             NEG_AUTO,
    output logic             NEG_ANALOG_GROUND,
    output logic             NEG_ANALOG_INPUT_7
);
    // ****************************************************************
    // register and bus decode
    // ****************************************************************
    logic [15:0]        cfg_reg;
    logic [15:0]        cfg_next;
    logic [15:0]        cfg_load;
    logic [15:0]        rdata_reg;
    logic [15:0]        rdata_next;
    logic [18:0]        dec_reg;
    wire  logic [18:0]  dec_next;
    wire  logic         hit;
    wire  ssc_pkg::ssc_gain_t gain_next;
    wire  logic [7:0]   ext_next;
    wire  logic         temp_next;
    wire  logic         short_next;
    wire  logic         test_next;
    wire  logic         analog_power_supply_next;
    wire  logic         digital_power_supply_next;
    wire  logic         auto_next;
    wire  logic         gnd_next;
    wire  logic         in7_next;

    assign hit        = (ADDR == ssc_pkg::STEP_FIVE_CFG_ADDR);
    assign cfg_next   = (WR && hit) ? (WDATA & ssc_pkg::STEP_FIVE_CFG_WMASK) : cfg_reg;
    assign rdata_next = (RD && hit) ? (cfg_reg & ssc_pkg::STEP_FIVE_CFG_WMASK)
                                    : ssc_pkg::UNMAPPED_READ_VALUE;

    always_ff @(posedge CLK) begin
        if (RST) begin
            cfg_reg   <= ssc_pkg::STEP_FIVE_CFG_RESET;
            rdata_reg <= ssc_pkg::UNMAPPED_READ_VALUE;
        end else begin
            cfg_reg   <= cfg_next;
            rdata_reg <= rdata_next;
        end
    end

    assign RDATA               = rdata_reg;
    assign STEP_INCLUDE_ENABLE = cfg_reg[ssc_pkg::EN_BIT];

    // ****************************************************************
    // field decoders, registered beside the configuration word
    // ****************************************************************
    // decode the value being loaded, reset included, so selects change with the register
    assign cfg_load = RST ? ssc_pkg::STEP_FIVE_CFG_RESET : cfg_next;
    assign dec_next = {gain_next, ext_next, temp_next, short_next, test_next,
                       analog_power_supply_next, digital_power_supply_next, auto_next, gnd_next, in7_next};

    always_ff @(posedge CLK) begin
        dec_reg <= dec_next;
    end

    assign STEP_GAIN_ONEHOT    = dec_reg[18:16];
    assign POS_EXTERNAL_ONEHOT = dec_reg[15:8];
    assign POS_TEMP_SENSOR     = dec_reg[7];
    assign POS_SHORT_GND       = dec_reg[6];
    assign POS_TEST_SOURCE     = dec_reg[5];
    assign POS_ANALOG_PWR      = dec_reg[4];
    assign POS_DIGITAL_PWR     = dec_reg[3];
    assign NEG_AUTO            = dec_reg[2];
    assign NEG_ANALOG_GROUND   = dec_reg[1];
    assign NEG_ANALOG_INPUT_7  = dec_reg[0];

    ssc_gain_decode u_gain (
        .code (cfg_load[ssc_pkg::GAIN_HI:ssc_pkg::GAIN_LO]),
        .gain (gain_next)
    );

    ssc_input_decode u_input (
        .pos_code        (cfg_load[ssc_pkg::POS_HI:ssc_pkg::POS_LO]),
        .neg_sel         (cfg_load[ssc_pkg::NEG_BIT]),
        .pos_ext_onehot  (ext_next),
        .pos_temp_sensor (temp_next),
        .pos_short_gnd   (short_next),
        .pos_test_source (test_next),
        .pos_analog_pwr  (analog_power_supply_next),
        .pos_digital_pwr (digital_power_supply_next),
        .neg_auto        (auto_next),
        .neg_ground      (gnd_next),
        .neg_input_7     (in7_next)
    );
endmodule // ssc_step_config
`default_nettype wire

// file: ssc_step_config_chk.sv
// checker: port assertions of the step-five configuration register
`timescale 1ns/100ps
`default_nettype none
module ssc_step_config_chk (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [7:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic [15:0] RDATA,
    input wire logic        STEP_INCLUDE_ENABLE,
    input wire logic [2:0]  STEP_GAIN_ONEHOT,
    input wire logic [7:0]  POS_EXTERNAL_ONEHOT,
    input wire logic        POS_TEMP_SENSOR,
    input wire logic        POS_SHORT_GND,
    input wire logic        POS_TEST_SOURCE,
    input wire logic        POS_ANALOG_PWR,
    input wire logic        POS_DIGITAL_PWR,
    input wire logic        NEG_AUTO,
    input wire logic        NEG_ANALOG_GROUND,
    input wire logic        NEG_ANALOG_INPUT_7
);
    // ****
    // assertions
    // ****
    wire hit = WR && !RST && ADDR == ssc_pkg::STEP_FIVE_CFG_ADDR;
    wire [3:0] c = WDATA[3:0];
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_enable_bit: assert property (hit |=> STEP_INCLUDE_ENABLE == $past(WDATA[15]))
        else $error("enable wrong");
    a_gain_map: assert property (hit |=> STEP_GAIN_ONEHOT ==
        ($past(WDATA[14]) ? 3'h4 : $past(WDATA[13]) ? 3'h2 : 3'h1)) else $error("gain wrong");
    a_neg_manual: assert property (hit && !c[3] |=> NEG_ANALOG_INPUT_7 == $past(WDATA[4])
        && NEG_ANALOG_GROUND == !$past(WDATA[4]) && !NEG_AUTO) else $error("neg select wrong");
    a_ext_route: assert property (hit |=> POS_EXTERNAL_ONEHOT ==
        ($past(c[3]) ? 8'h00 : 8'h01 << $past(c[2:0]))) else $error("ext route wrong");
    a_int_source: assert property (hit |=> POS_TEST_SOURCE == ($past(c) == 4'hA) &&
        POS_TEMP_SENSOR == ($past(c) == 4'h8) && POS_SHORT_GND == ($past(c) == 4'h9))
        else $error("internal source wrong");
    a_supply_pick: assert property (hit |=> POS_ANALOG_PWR == ($past(c) == 4'hE) &&
        POS_DIGITAL_PWR == ($past(c) == 4'hF)) else $error("supply wrong");
    a_neg_auto: assert property (hit && c[3] |=> NEG_AUTO && !NEG_ANALOG_GROUND
        && !NEG_ANALOG_INPUT_7) else $error("auto neg wrong");
    a_rsv_zero: assert property (RD && ADDR == ssc_pkg::STEP_FIVE_CFG_ADDR |=>
        RDATA[12:5] == 8'h00) else $error("reserved not zero");
    c_enable: cover property (hit && WDATA[15]);
    c_internal: cover property (hit && c[3]);
    c_read: cover property (RD && ADDR == ssc_pkg::STEP_FIVE_CFG_ADDR);
endmodule // ssc_step_config_chk
`default_nettype wire

// file: ssc_step_config_tb_top.sv
// testbench: register access and decode of the step-five configuration register
`timescale 1ns/100ps
`default_nettype none
module ssc_step_config_tb_top;
    logic        CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0;
    logic [7:0]  ADDR = 8'h00;
    logic [15:0] WDATA = 16'h0000;
    wire  [15:0] RDATA;
    wire  [19:0] o;
    int          n_errors = 0, checks = 0;
    always #10 CLK = ~CLK;
    ssc_step_config DUT (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .STEP_INCLUDE_ENABLE(o[19]), .STEP_GAIN_ONEHOT(o[18:16]),
        .POS_EXTERNAL_ONEHOT(o[15:8]), .POS_TEMP_SENSOR(o[7]), .POS_SHORT_GND(o[6]),
        .POS_TEST_SOURCE(o[5]), .POS_ANALOG_PWR(o[4]), .POS_DIGITAL_PWR(o[3]),
        .NEG_AUTO(o[2]), .NEG_ANALOG_GROUND(o[1]), .NEG_ANALOG_INPUT_7(o[0]));
    // ****
    // tasks
    // ****
    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [19:0] dec(input logic [15:0] v);
        return {v[15], v[14] ? 3'h4 : v[13] ? 3'h2 : 3'h1, v[3] ? 8'h00 : 8'h01 << v[2:0],
            v[3:0] == 4'h8, v[3:0] == 4'h9, v[3:0] == 4'hA, v[3:0] == 4'hE, v[3:0] == 4'hF,
            v[3], !v[3] & !v[4], !v[3] & v[4]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk("read data", {4'h0, e}, {4'h0, RDATA});
        @(posedge CLK);
    endtask
    task automatic t_reset;
        rd(8'h95, 16'h0005);
        chk("reset decode", dec(16'h0005), o);
        $display("test reset done");
    endtask
    task automatic t_fields;
        logic [15:0] v;
        for (int i = 0; i < 32; i++) begin
            v = {i[0], i[2:1], 8'hFF, i[4:0]};
            wr(8'h95, v);
            rd(8'h95, v & 16'hE01F);
            chk("decode", dec(v), o);
        end
        $display("test fields done");
    endtask
    task automatic t_unmapped;
        wr(8'h94, 16'h0000);
        rd(8'h94, 16'h0000);
        rd(8'h95, 16'hE01F);
        $display("test unmapped done");
    endtask
    task automatic t_midreset;
        wr(8'h95, 16'h8013);
        rd(8'h95, 16'h8013);
        RST <= 1'b1;
        @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        rd(8'h95, 16'h0005);
        chk("mid reset decode", dec(16'h0005), o);
        $display("test mid reset done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        t_reset;
        t_fields;
        t_unmapped;
        t_midreset;
        wrap_up;
    end
    initial begin
        #(20 * 500);
        n_errors++;
        wrap_up;
    end
endmodule // ssc_step_config_tb_top
bind ssc_step_config ssc_step_config_chk u_chk (
    .CLK                 (CLK),
    .RST                 (RST),
    .WR                  (WR),
    .RD                  (RD),
    .ADDR                (ADDR),
    .WDATA               (WDATA),
    .RDATA               (RDATA),
    .STEP_INCLUDE_ENABLE (STEP_INCLUDE_ENABLE),
    .STEP_GAIN_ONEHOT    (STEP_GAIN_ONEHOT),
    .POS_EXTERNAL_ONEHOT (POS_EXTERNAL_ONEHOT),
    .POS_TEMP_SENSOR     (POS_TEMP_SENSOR),
    .POS_SHORT_GND       (POS_SHORT_GND),
    .POS_TEST_SOURCE     (POS_TEST_SOURCE),
    .POS_ANALOG_PWR      (POS_ANALOG_PWR),
    .POS_DIGITAL_PWR     (POS_DIGITAL_PWR),
    .NEG_AUTO            (NEG_AUTO),
    .NEG_ANALOG_GROUND   (NEG_ANALOG_GROUND),
    .NEG_ANALOG_INPUT_7  (NEG_ANALOG_INPUT_7)
);
`default_nettype wire
